// ==== include/pms_pkg.sv ====
// Purpose: Shared constants and types for the program memory sequencer
// Assumes: 1K x 16 program store, 8-bit data path
// Notes:   All addresses and reset values live here
package pms_pkg;
   // ==========================================================
   // Memory map
   localparam int          ADDR_W       = 10;
   localparam int          WORD_W       = 16;
   localparam int          MEM_WORDS    = 1024;
   localparam logic [9:0]  RESET_VECTOR = 10'h000;
   localparam logic [9:0]  IRQ_VECTOR   = 10'h008;
   localparam logic [9:0]  RESERVED_LO  = 10'h3FD;
   // ==========================================================
   // Stack and byte layout
   localparam int          STACK_DEPTH  = 4;
   localparam int          PTR_W        = 2;
   localparam logic [7:0]  BYTE_ZERO    = 8'h00;
   localparam logic [15:0] WORD_ZERO    = 16'h0000;
   localparam logic [9:0]  ADDR_ZERO    = 10'h000;
   localparam logic [9:0]  ADDR_ONE     = 10'h001;
   localparam logic [1:0]  PTR_ZERO     = 2'h0;
   localparam logic [1:0]  PTR_ONE      = 2'h1;
   localparam int          HI_LSB       = 8;
   // ==========================================================
   // Program flag layout: bit7 timeout, bit6 powerdown, low bits user
   localparam int          FLAG_TO_BIT  = 7;
   localparam int          FLAG_PD_BIT  = 6;
   localparam logic [7:0]  FLAG_USER_M  = 8'h3F;
   localparam logic [7:0]  FLAG_RESET   = 8'h00;
   localparam logic [7:0]  ACC_RESET    = 8'h00;
   // ==========================================================
   // Reset causes and sequencer states
   typedef enum logic [1:0] {
      CAUSE_POWER = 2'b00,
      CAUSE_WDT   = 2'b01,
      CAUSE_EXT   = 2'b10
   } pms_cause_t;
   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_TWAIT = 2'b01,
      ST_TDONE = 2'b11
   } pms_state_t;
endpackage

// ==== include/pms_mem_if.sv ====
// Purpose: Read port bundle between sequencer and program store
// Assumes: Single clock, registered read data
// Notes:   Write port used only for loading the store
`timescale 1ns/1ps
`default_nettype none
interface pms_mem_if;
   logic [9:0]  rdAddr;
   logic [15:0] rdData;
   logic        wrEn;
   logic [9:0]  wrAddr;
   logic [15:0] wrData;
   modport master (output rdAddr, output wrEn, output wrAddr, output wrData, input rdData);
   modport store  (input rdAddr, input wrEn, input wrAddr, input wrData, output rdData);
endinterface
`default_nettype wire

// ==== rtl/pms_rom.sv ====
// Purpose: Program word store with registered read data
// Assumes: One read per clock, read data one cycle after address
// Notes:   Contents loaded through the write port
`timescale 1ns/1ps
`default_nettype none
module pms_rom #(
   parameter int DEPTH = pms_pkg::MEM_WORDS
) (
   // Clock
   input  wire logic clk_sys,
   // Store port
   pms_mem_if.store  mem
);
   logic [15:0] words [DEPTH];
   // ==========================================================
   // Storage, no reset so it maps onto block memory
   always_ff @(posedge clk_sys) begin
      if (mem.wrEn) begin
         words[mem.wrAddr] <= mem.wrData;
      end
      mem.rdData <= words[mem.rdAddr];
   end
endmodule
`default_nettype wire

// ==== rtl/pms_sequencer.sv ====
// Purpose: Program counter sequencing, vectors, stack, context save, table read
// Assumes: One instruction request per cycle, decoded by the core outside
// Notes:   Table read takes three cycles because store data is registered
//
// Behaviour
// R1 - The program store holds 1K words of 16 bits with reset, interrupt and reserved areas.
// R2 - Address zero is the reset vector and fetch starts there after any reset.
// R3 - Any of the three resets restarts at zero and returns all registers to defaults.
// R4 - Reset cause sets timeout and powerdown flags to 1/0, 0/0 or 1/1.
// R5 - Interrupt entry pushes the program counter then fetches from address eight.
// R6 - Every interrupt source enters through the one common vector.
// R7 - Context save and restore copy working and flag registers, skipping the cause flags.
// R8 - Table read address takes high index as bits 8 to 15 and low index as bits 0 to 7.
// R9 - Table read puts the low byte in the working register and high byte in read-data high.
// R10 - The low index wrapping never carries into the high index.
// R11 - The external reset pin is active low and idles high.
// R12 - Adding to the pc low byte carries into the high byte; a borrow does not.
// R13 - The return stack is four levels deep for calls and interrupt entry.
// R14 - Interrupt return reloads the program counter from the top of stack.
`timescale 1ns/1ps
`default_nettype none
module pms_sequencer #(
   parameter int STACK_DEPTH = pms_pkg::STACK_DEPTH
) (
   // Clock and resets
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire logic        extReset_n,
   input  wire logic        wdtReset,
   // Instruction requests, one-cycle pulses
   input  wire logic        stepReq,
   input  wire logic        jumpReq,
   input  wire logic        callReq,
   input  wire logic        retReq,
   input  wire logic        irqReq,
   input  wire logic        interrupt_return,
   input  wire logic        pushReq,
   input  wire logic        popReq,
   input  wire logic        addPcReq,
   input  wire logic        subPcReq,
   input  wire logic        table_read_instruction,
   input  wire logic [9:0]  targetAddr,
   // Register writes from the core
   input  wire logic        accWrEn,
   input  wire logic [7:0]  accWrData,
   input  wire logic        flagWrEn,
   input  wire logic [7:0]  flagWrData,
   input  wire logic        idxHiWrEn,
   input  wire logic        idxLoWrEn,
   input  wire logic        idxLoInc,
   input  wire logic [7:0]  idxWrData,
   // Store load port
   input  wire logic        loadEn,
   input  wire logic [9:0]  loadAddr,
   input  wire logic [15:0] loadData,
   // State out
   output logic [9:0]       pc,
   output logic [15:0]      instrWord,
   output logic [7:0]       working_register,
   output logic [7:0]       program_flag_register,
   output logic [7:0]       readHigh,
   output logic [7:0]       idxHigh,
   output logic [7:0]       idxLow,
   output logic             busy,
   output logic             stackOverflow
);
   // ==========================================================
   // Reset cause capture
   logic       extSeen;
   logic       softReset;
   logic       softResetDly;
   // Pin sampled as synchronous; low requests reset
   assign softReset = ~extReset_n | wdtReset; // R11

   // Marks the first cycle after a sync reset, when the cause flags load
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         softResetDly <= 1'b0;
      end else begin
         softResetDly <= softReset;
      end
   end

   // Latched cause for the flag update when the reset ends
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         extSeen <= 1'b0;
      end else if (softReset) begin
         // Pin low wins over watchdog; watchdog alone leaves 0/0
         extSeen <= ~extReset_n;
      end
   end

   // Cause flags: power-on gives 1/0 at the async reset itself
   logic next_timeout;
   logic next_powerdown;
   assign next_timeout   = extSeen; // R4
   assign next_powerdown = extSeen; // R4

   // ==========================================================
   // Store and stack
   pms_mem_if memBus ();
   pms_rom #(.DEPTH(pms_pkg::MEM_WORDS)) romInst ( // R1
      .clk_sys (clk_sys),
      .mem     (memBus.store)
   );

   logic [9:0] stack [STACK_DEPTH];
   logic [1:0] stackPtr;
   logic       stackFull;
   localparam int LAST_LEVEL = STACK_DEPTH - 1;
   logic [9:0] stackTop;
   logic [7:0] saveAcc;
   logic [7:0] saveFlag;
   pms_pkg::pms_state_t state;
   pms_pkg::pms_state_t next_state;

   // Function: word index of a byte pair, high index bits above bit 1 dropped
   function automatic logic [9:0] tableAddr(input logic [7:0] hi, input logic [7:0] lo);
      logic [15:0] full;
      full = {hi, lo}; // R8
      return full[9:0];
   endfunction

   // ==========================================================
   // Next program counter selection
   logic [7:0] pcLow;
   logic [1:0] pcHigh;
   logic [8:0] addSum;
   logic [8:0] subDiff;
   logic [9:0] next_pc;
   logic [9:0] pcInc;
   logic       tableStart;
   assign pcLow      = pc[7:0];
   assign pcHigh     = pc[9:8];
   assign addSum     = {1'b0, pcLow} + {1'b0, working_register};
   assign subDiff    = {1'b0, pcLow} - {1'b0, working_register};
   assign pcInc      = pc + pms_pkg::ADDR_ONE;
   assign stackTop   = stack[stackPtr - pms_pkg::PTR_ONE];
   assign tableStart = table_read_instruction && (state == pms_pkg::ST_RUN);

   always_comb begin
      next_pc = pc;
      if (state != pms_pkg::ST_RUN) begin
         next_pc = pc;
      end else if (irqReq) begin
         next_pc = pms_pkg::IRQ_VECTOR; // R5 R6
      end else if (interrupt_return || retReq) begin
         next_pc = stackTop; // R14
      end else if (jumpReq || callReq) begin
         next_pc = targetAddr;
      end else if (addPcReq) begin
         // Carry bumps the high bits
         next_pc = {pcHigh + {1'b0, addSum[8]}, addSum[7:0]}; // R12
      end else if (subPcReq) begin
         // Borrow deliberately ignored
         next_pc = {pcHigh, subDiff[7:0]}; // R12
      end else if (stepReq) begin
         next_pc = pcInc;
      end
   end

   // Table read sequencing
   always_comb begin
      case (state)
         pms_pkg::ST_RUN:   next_state = tableStart ? pms_pkg::ST_TWAIT : pms_pkg::ST_RUN;
         pms_pkg::ST_TWAIT: next_state = pms_pkg::ST_TDONE;
         pms_pkg::ST_TDONE: next_state = pms_pkg::ST_RUN;
         default:           next_state = pms_pkg::ST_RUN;
      endcase
   end

   // Store address: table index during table read, else next fetch
   // Held through the wait state since the store re-reads every cycle
   assign memBus.rdAddr = (tableStart || (state == pms_pkg::ST_TWAIT)) ?
                          tableAddr(idxHigh, idxLow) : next_pc;
   assign memBus.wrEn   = loadEn;
   assign memBus.wrAddr = loadAddr;
   assign memBus.wrData = loadData;

   // ==========================================================
   // Program counter, state and stack
   logic pushRet;
   logic popRet;
   assign pushRet = (state == pms_pkg::ST_RUN)
                    && (irqReq || (callReq && !interrupt_return && !retReq));
   assign popRet  = (state == pms_pkg::ST_RUN) && !irqReq && (interrupt_return || retReq);

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pc    <= pms_pkg::RESET_VECTOR; // R2 R3
         state <= pms_pkg::ST_RUN;
      end else if (softReset) begin
         pc    <= pms_pkg::RESET_VECTOR; // R2 R3
         state <= pms_pkg::ST_RUN;
      end else begin
         pc    <= next_pc;
         state <= next_state;
      end
   end

   // Call pushes return point, interrupt pushes the current pc
   // Full marks the last slot taken, so only a push beyond it overflows
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         stackPtr      <= pms_pkg::PTR_ZERO;
         stackFull     <= 1'b0;
         stackOverflow <= 1'b0;
      end else if (softReset) begin
         stackPtr      <= pms_pkg::PTR_ZERO;
         stackFull     <= 1'b0;
         stackOverflow <= 1'b0;
      end else if (pushRet) begin
         stackPtr      <= stackPtr + pms_pkg::PTR_ONE; // R13
         stackFull     <= stackFull | (stackPtr == LAST_LEVEL[pms_pkg::PTR_W - 1:0]);
         stackOverflow <= stackOverflow | stackFull; // R13
      end else if (popRet) begin
         stackPtr      <= stackPtr - pms_pkg::PTR_ONE; // R13 R14
         stackFull     <= 1'b0;
      end
   end

   // Stack words, wraps like a ring when four deep is exceeded
   always_ff @(posedge clk_sys) begin
      if (pushRet) begin
         stack[stackPtr] <= irqReq ? pc : pcInc; // R5 R13
      end
   end

   // ==========================================================
   // Working, flag, index and read-high registers
   logic tableDone;
   assign tableDone = (state == pms_pkg::ST_TDONE);
   localparam int HI_LSB_M = pms_pkg::HI_LSB;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         working_register <= pms_pkg::ACC_RESET;
         readHigh         <= pms_pkg::BYTE_ZERO;
         idxHigh          <= pms_pkg::BYTE_ZERO;
         idxLow           <= pms_pkg::BYTE_ZERO;
         saveAcc          <= pms_pkg::BYTE_ZERO;
         instrWord        <= pms_pkg::WORD_ZERO;
      end else if (softReset) begin
         working_register <= pms_pkg::ACC_RESET; // R3
         readHigh         <= pms_pkg::BYTE_ZERO;
         idxHigh          <= pms_pkg::BYTE_ZERO;
         idxLow           <= pms_pkg::BYTE_ZERO;
         saveAcc          <= pms_pkg::BYTE_ZERO;
         instrWord        <= pms_pkg::WORD_ZERO;
      end else begin
         instrWord <= memBus.rdData;
         if (tableDone) begin
            working_register <= memBus.rdData[HI_LSB_M - 1:0]; // R9
            readHigh         <= memBus.rdData[pms_pkg::WORD_W - 1:HI_LSB_M]; // R9
         end else if (popReq) begin
            working_register <= saveAcc; // R7
         end else if (accWrEn) begin
            working_register <= accWrData;
         end
         if (pushReq) begin
            saveAcc <= working_register; // R7
         end
         if (idxHiWrEn) begin
            idxHigh <= idxWrData;
         end
         // Wrap stays inside the low byte
         if (idxLoWrEn) begin
            idxLow <= idxWrData;
         end else if (idxLoInc) begin
            idxLow <= idxLow + 8'h01; // R10
         end
      end
   end

   // Flag register: cause bits kept apart from push/pop and software
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         program_flag_register <= pms_pkg::FLAG_RESET;
         program_flag_register[pms_pkg::FLAG_TO_BIT] <= 1'b1; // R4
         saveFlag <= pms_pkg::BYTE_ZERO;
      end else if (softReset) begin
         program_flag_register <= pms_pkg::FLAG_RESET;
         saveFlag <= pms_pkg::BYTE_ZERO;
      end else begin
         if (softResetDly) begin
            program_flag_register[pms_pkg::FLAG_TO_BIT] <= next_timeout; // R4
            program_flag_register[pms_pkg::FLAG_PD_BIT] <= next_powerdown; // R4
         end
         if (popReq) begin
            program_flag_register[5:0] <= saveFlag[5:0]; // R7
         end else if (flagWrEn) begin
            program_flag_register[5:0] <= flagWrData[5:0];
         end
         if (pushReq) begin
            saveFlag <= program_flag_register & pms_pkg::FLAG_USER_M; // R7
         end
      end
   end

   // Busy while a table read is in flight
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
      end else begin
         busy <= ~softReset & (tableStart | (state == pms_pkg::ST_TWAIT));
      end
   end
endmodule
`default_nettype wire

// ==== tb/pms_seq_checker.sv ====
// Purpose: Port assertions for the sequencer
// Assumes: One clock, async reset low
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module pms_seq_checker (
   // Clock and resets
   input wire logic       clk_sys,
   input wire logic       arst_n,
   input wire logic       extReset_n,
   input wire logic       wdtReset,
   // Requests
   input wire logic       irqReq,
   input wire logic       interrupt_return,
   input wire logic       table_read_instruction,
   input wire logic       idxLoInc,
   input wire logic       idxHiWrEn,
   input wire logic       idxLoWrEn,
   // State
   input wire logic [9:0] pc,
   input wire logic [7:0] working_register,
   input wire logic [7:0] program_flag_register,
   input wire logic [7:0] idxHigh,
   input wire logic [7:0] idxLow,
   input wire logic       busy
);
   // ====================
   // Sequences
   wire logic ok;
   // Sync resets win over any request
   assign ok = extReset_n && !wdtReset;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   sequence irqIn; irqReq && !busy && ok; endsequence
   sequence irqOut; interrupt_return && !irqReq && ok; endsequence
   sequence trIn; table_read_instruction && !busy && ok; endsequence
   sequence extOut; !extReset_n && !wdtReset ##1 ok; endsequence
   // ====================
   // Properties
   irq_vector_a: assert property (irqIn |=> pc == 10'h008)
      else $error("irq entry missed vector");
   irq_return_a: assert property (irqIn ##1 irqOut |=> pc == $past(pc, 2))
      else $error("return address wrong");
   ext_reset_a: assert property (!extReset_n |=> pc == 10'h000)
      else $error("ext reset kept pc");
   wdt_reset_a: assert property (wdtReset |=> working_register == 8'h00)
      else $error("wdt reset kept acc");
   power_flags_a: assert property ($rose(arst_n) |-> program_flag_register == 8'h80)
      else $error("power-on flags wrong");
   ext_flags_a: assert property (extOut |-> ##[0:2] program_flag_register[7:6] == 2'b11)
      else $error("ext reset flags wrong");
   tread_busy_a: assert property (trIn |=> busy [*2] ##1 !busy)
      else $error("table read timing wrong");
   busy_hold_a: assert property (busy && ok |=> $stable(pc))
      else $error("pc moved during read");
   idx_wrap_a: assert property (idxLoInc && !idxLoWrEn && !idxHiWrEn && ok
      && idxLow == 8'hFF |=> idxLow == 8'h00 && $stable(idxHigh))
      else $error("index carry seen");
endmodule
`default_nettype wire

// ==== tb/pms_irq_model.sv ====
// Purpose: Interrupt sources beside the sequencer
// Assumes: Each fire input is a one-cycle pulse
// Notes:   Request lags the source by one cycle
`timescale 1ns/1ps
`default_nettype none
module pms_irq_model (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   // Source events
   input  wire logic [2:0] srcFire,
   // Shared request
   output logic            irqReq
);
   // ====================
   // Merge: no per-source entry exists, so all share one line
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irqReq <= 1'b0;
      end else begin
         irqReq <= |srcFire;
      end
   end
endmodule
`default_nettype wire

// ==== tb/program_memory_sequencer_tb.sv ====
// Purpose: Self-checking bench for the sequencer
// Assumes: Requests one at a time with idle cycles, except interrupt return right behind entry
// Notes:   Expected values queued, checked at negedge
`timescale 1ns/1ps
`default_nettype none
module program_memory_sequencer_tb;
   typedef struct {int s; logic [15:0] e;} pms_note_t;
   logic        clk_sys = 1'b0;
   logic        arst_n = 1'b0;
   logic        extReset_n = 1'b1;
   logic        wdtReset = 1'b0;
   logic [15:0] req = '0;
   logic [15:0] dat = '0;
   logic [9:0]  adr = '0;
   logic [2:0]  srcFire = '0;
   logic        irqReq, busy, stackOverflow;
   logic [9:0]  pc, ta;
   logic [15:0] instrWord, w;
   logic [7:0]  working_register, program_flag_register, readHigh, idxHigh, idxLow;
   logic [9:0]  stk[4];
   int          mismatches = 0;
   int          checks = 0;
   int          cyc = 0;
   pms_note_t   notes[$];
   string       nm[7] = '{"pc", "acc", "flags", "readHigh", "index", "overflow", "instrWord"};
   // ====================
   // Clock, design and partner
   always #2 clk_sys = ~clk_sys;
   pms_sequencer dut (.clk_sys, .arst_n, .extReset_n, .wdtReset, .stepReq(req[0]),
      .jumpReq(req[1]), .callReq(req[2]), .retReq(req[3]), .irqReq,
      .interrupt_return(req[9]), .pushReq(req[4]), .popReq(req[5]), .addPcReq(req[6]),
      .subPcReq(req[7]), .table_read_instruction(req[8]), .targetAddr(adr),
      .accWrEn(req[11]), .accWrData(dat[7:0]), .flagWrEn(req[12]), .flagWrData(dat[7:0]),
      .idxHiWrEn(req[13]), .idxLoWrEn(req[14]), .idxLoInc(req[10]), .idxWrData(dat[7:0]),
      .loadEn(req[15]), .loadAddr(adr), .loadData(dat), .pc, .instrWord,
      .working_register, .program_flag_register, .readHigh, .idxHigh, .idxLow, .busy,
      .stackOverflow);
   pms_irq_model irqm (.clk_sys, .arst_n, .srcFire, .irqReq);
   // ====================
   // Tasks
   function automatic logic [15:0] obs(int s);
      case (s)
         0: return {6'h00, pc};
         1: return {8'h00, working_register};
         2: return {8'h00, program_flag_register};
         3: return {8'h00, readHigh};
         4: return {idxHigh, idxLow};
         6: return instrWord;
         default: return {15'h0000, stackOverflow};
      endcase
   endfunction
   task automatic check(int s, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm[s], exp, seen);
      end
   endtask
   task automatic note(int s, logic [15:0] e);
      notes.push_back('{s, e});
   endtask
   // One request pulse; returns at the edge that takes it
   task automatic go(int b, logic [9:0] a, logic [15:0] d);
      @(posedge clk_sys);
      req <= 16'h0001 << b;
      adr <= a;
      dat <= d;
      @(posedge clk_sys);
      req <= '0;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Monitor: settled outputs against the oldest notes
   always @(negedge clk_sys) begin
      while (notes.size() > 0) begin
         check(notes[0].s, obs(notes[0].s), notes[0].e);
         void'(notes.pop_front());
      end
   end
   // Hang guard, well above the run length
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         wrap_up();
      end
   end
   // ====================
   // Scenarios
   initial begin
      void'($urandom(32'h1746));
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      note(0, 16'h0000);
      note(2, 16'h0080);
      // Table reads, top word first; one with a jump refused mid-read
      for (int i = 0; i < 4; i++) begin
         ta = (i == 0) ? 10'h3FF : 10'($urandom());
         w = 16'($urandom());
         go(15, ta, w);
         go(13, 0, {14'h0000, ta[9:8]});
         go(14, 0, {8'h00, ta[7:0]});
         go(8, 0, 16'h0000);
         if (i == 1) begin
            go(1, 10'h2AA, 16'h0000);
            @(posedge clk_sys);
         end else begin
            repeat (3) @(posedge clk_sys);
         end
         note(1, {8'h00, w[7:0]});
         note(3, {8'h00, w[15:8]});
         note(0, 16'h0000);
      end
      // Fetch word follows the pc one cycle later
      go(1, ta, 16'h0000);
      @(posedge clk_sys);
      note(6, w);
      go(13, 0, 16'h0001);
      go(14, 0, 16'h00FF);
      go(10, 0, 16'h0000);
      note(4, 16'h0100);
      go(11, 0, 16'h0020);
      go(1, 10'h0F0, 16'h0000);
      go(6, 0, 16'h0000);
      note(0, 16'h0110);
      go(1, 10'h105, 16'h0000);
      go(7, 0, 16'h0000);
      note(0, 16'h01E5);
      // Four nested calls unwind in order; a fifth push overflows
      ta = 10'h040;
      go(1, ta, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         stk[i] = ta + 10'h001;
         ta = 10'($urandom());
         go(2, ta, 16'h0000);
      end
      for (int i = 3; i >= 0; i--) begin
         go(3, 0, 16'h0000);
         note(0, {6'h00, stk[i]});
      end
      note(5, 16'h0000);
      for (int i = 0; i < 5; i++) go(2, 10'h050, 16'h0000);
      note(5, 16'h0001);
      // Every source enters at the one vector and returns
      for (int i = 0; i < 3; i++) begin
         ta = 10'($urandom());
         go(1, ta, 16'h0000);
         @(posedge clk_sys);
         srcFire <= 3'h1 << i;
         @(posedge clk_sys);
         srcFire <= '0;
         @(posedge clk_sys);
         note(0, 16'h0008);
         // Return right behind the entry, so the checker sees the pair
         req <= 16'h0200;
         @(posedge clk_sys);
         req <= '0;
         note(0, {6'h00, ta});
      end
      // Context save keeps cause flags out of the copy
      go(11, 0, 16'h005A);
      go(12, 0, 16'h0015);
      go(4, 0, 16'h0000);
      go(11, 0, 16'h00A5);
      go(12, 0, 16'h002A);
      go(5, 0, 16'h0000);
      note(1, 16'h005A);
      note(2, 16'h0095);
      // External then watchdog reset from the run state, after a jump
      for (int k = 0; k < 2; k++) begin
         go(11, 0, 16'h0077);
         go(1, 10'h123, 16'h0000);
         if (k == 0) extReset_n <= 1'b0;
         else wdtReset <= 1'b1;
         repeat (3) @(posedge clk_sys);
         extReset_n <= 1'b1;
         wdtReset <= 1'b0;
         repeat (2) @(posedge clk_sys);
         note(0, 16'h0000);
         note(1, 16'h0000);
         note(2, (k == 0) ? 16'h00C0 : 16'h0000);
      end
      @(negedge clk_sys);
      wrap_up();
   end
endmodule
bind pms_sequencer pms_seq_checker chk (.clk_sys, .arst_n, .extReset_n, .wdtReset,
   .irqReq, .interrupt_return, .table_read_instruction, .idxLoInc, .idxHiWrEn,
   .idxLoWrEn, .pc, .working_register, .program_flag_register, .idxHigh, .idxLow, .busy);
`default_nettype wire
